/* File: rtl/pwr_seq_pkg.sv */
// Constants, state encoding and register map of the power state machine.
// Assumes a single 125 MHz clock and APB access from the host side.

package pwr_seq_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned SWOFF_TIME_US    = 500;
  localparam int unsigned SWOFF_CYC        = SWOFF_TIME_US * CLK_MHZ;
  localparam int unsigned ST_GAP_TIME_US   = 2000;
  localparam int unsigned ST_GAP_CYC       = ST_GAP_TIME_US * CLK_MHZ;
  localparam int unsigned HOLD_TIME_US     = 1000;
  localparam int unsigned HOLD_CYC         = HOLD_TIME_US * CLK_MHZ;
  localparam int unsigned OV_DBNC_TIME_US  = 10;
  localparam int unsigned OV_DBNC_CYC      = OV_DBNC_TIME_US * CLK_MHZ;
  localparam int unsigned ST_MAX_TRIES     = 3;
  localparam int unsigned TMR_W            = 20;

  // ==========================================================================
  // States
  typedef enum logic [9:0] {
    S_FUSE_LOAD  = 10'h001,
    S_LOW_POWER_OFF_STATE     = 10'h002,
    S_SELF_TEST  = 10'h004,
    S_QUICK_OFF  = 10'h008,
    S_POWER_UP   = 10'h010,
    S_SYSTEM_ON  = 10'h020,
    S_PD_REQ     = 10'h040,
    S_PD_FAULT   = 10'h080,
    S_FS_TRANS   = 10'h100,
    S_FS_LOCK    = 10'h200
  } pwr_state_e;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] LIMIT_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] COUNT_OFS   = 8'h0C;

  localparam int unsigned CTRL_LPM_BIT    = 0;
  localparam int unsigned CTRL_SWOFF_BIT  = 1;
  localparam int unsigned CTRL_OVSD_BIT   = 2;
  localparam int unsigned CTRL_EDGE_BIT   = 3;
  localparam int unsigned CTRL_BYP_BIT    = 4;
  localparam int unsigned LIM_FS_LSB      = 4;
  localparam int unsigned STAT_TRIM_BIT   = 16;
  localparam int unsigned STAT_CFG_BIT    = 17;
  localparam int unsigned STAT_STEST_BIT  = 18;
  localparam int unsigned STAT_RST_BIT    = 19;
  localparam int unsigned CNT_TRY_LSB     = 8;

  localparam logic [3:0] FAULT_LIM_RST = 4'h3;
  localparam logic [3:0] FS_LIM_RST    = 4'h3;

endpackage : pwr_seq_pkg

/* File: rtl/pwr_state_machine.sv */
// Top-level power state machine with APB register access.
// Assumes all status inputs are synchronous to SYS_CLK and that the rail
// sequencer, fuse loader and self-test engine answer with done pulses.
//
// Local design decisions: the register addresses and the APB register port.

`timescale 1ns/1ns

module pwr_state_machine #(
  parameter int unsigned SWOFF_CYCLES  = pwr_seq_pkg::SWOFF_CYC,
  parameter int unsigned ST_GAP_CYCLES = pwr_seq_pkg::ST_GAP_CYC,
  parameter int unsigned HOLD_CYCLES   = pwr_seq_pkg::HOLD_CYC
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  input  wire logic        POWER_ON_PIN,
  input  wire logic        TEST_MODE_ENABLE_PIN,
  input  wire logic        VIN_ABOVE_UV,
  input  wire logic        VIN_OVER_OV,
  input  wire logic        OV_LOCKOUT_DISABLE,
  input  wire logic        TJ_OVER_LIMIT,
  input  wire logic        DIGITAL_CORE_OK,
  input  wire logic        ANALOG_CORE_OK,
  input  wire logic        CONFIG_SELECT_PIN,
  input  wire logic        FUSE_LOAD_DONE,
  input  wire logic        FUSE_TRIM_CRC_ERR,
  input  wire logic        FUSE_CFG_CRC_ERR,
  input  wire logic        SELFTEST_DONE,
  input  wire logic        SELFTEST_PASS,
  input  wire logic        POWERUP_RESET_STEP,
  input  wire logic        POWERUP_FAIL,
  input  wire logic        POWERDOWN_DONE,
  input  wire logic        FAULT_TIMER_EXPIRED,
  input  wire logic [3:0]  FAULT_COUNTER,
  output logic             PROCESSOR_RESET_OUT_N,
  output logic             FUSE_LOAD_REQ,
  output logic             FUNC_LOAD_REQ,
  output logic             ALWAYS_ON_CFG,
  output logic             SELFTEST_START,
  output logic             POWERUP_START,
  output logic             POWERDOWN_START,
  output logic             FAILSAFE_LOCKED,
  output pwr_seq_pkg::pwr_state_e PMIC_STATE
);
  import pwr_seq_pkg::*;

  // ==========================================================================
  // State record
  typedef struct packed {
    pwr_state_e       st;
    logic             pin_d;
    logic             lpm;
    logic             swoff;
    logic             ovsd_en;
    logic             edge_mode;
    logic             fs_bypass;
    logic [3:0]       fault_lim;
    logic [3:0]       fs_lim;
    logic             trim_err;
    logic             cfg_err;
    logic             stest_err;
    logic [3:0]       failsafe_counter;
    logic [1:0]       st_tries;
    logic             busy;
    logic             armed;
    logic             hold_arm;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] sw_tmr;
    logic [TMR_W-1:0] ov_tmr;
    logic             rst_out_n;
    logic             fuse_req;
    logic             func_req;
    logic             aon_cfg;
    logic             st_start;
    logic             pu_start;
    logic             pd_start;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
  } pwr_s;

  localparam logic [TMR_W-1:0] SWOFF_T = TMR_W'(SWOFF_CYCLES);
  localparam logic [TMR_W-1:0] GAP_T   = TMR_W'(ST_GAP_CYCLES);
  localparam logic [TMR_W-1:0] HOLD_T  = TMR_W'(HOLD_CYCLES);
  localparam logic [TMR_W-1:0] OVDB_T  = TMR_W'(OV_DBNC_CYC);
  localparam logic [1:0]       TRIES_T = 2'(ST_MAX_TRIES);

  pwr_s r_r;
  pwr_s r_nxt;
  logic rst_sync1_r;
  logic rst_sync2_r;

  logic fall;
  logic pu_event;
  logic env_ok;
  logic flags_ok;
  logic fault_off;
  logic req_off;
  logic apb_acc;

  // ==========================================================================
  // Reset release
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end

  // ==========================================================================
  // Event qualification
  always_comb begin
    fall     = r_r.pin_d & ~POWER_ON_PIN;
    pu_event = r_r.edge_mode ? fall : POWER_ON_PIN;
    env_ok   = VIN_ABOVE_UV & (~VIN_OVER_OV | OV_LOCKOUT_DISABLE) & ~TJ_OVER_LIMIT;
    flags_ok = ~r_r.trim_err & ~r_r.cfg_err & ~r_r.stest_err;
    fault_off = FAULT_TIMER_EXPIRED | (FAULT_COUNTER == r_r.fault_lim)
              | TJ_OVER_LIMIT;
    req_off  = (~r_r.edge_mode & ~POWER_ON_PIN)
             | (r_r.hold_arm & (r_r.tmr >= HOLD_T))
             | (r_r.swoff & (r_r.sw_tmr >= SWOFF_T))
             | (r_r.ovsd_en & (r_r.ov_tmr >= OVDB_T));
    apb_acc  = PSEL & PENABLE & ~r_r.pready;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    r_nxt          = r_r;
    r_nxt.pin_d    = POWER_ON_PIN;
    r_nxt.fuse_req = 1'b0;
    r_nxt.func_req = 1'b0;
    r_nxt.aon_cfg  = 1'b0;
    r_nxt.st_start = 1'b0;
    r_nxt.pu_start = 1'b0;
    r_nxt.pd_start = 1'b0;
    r_nxt.pready   = 1'b0;
    r_nxt.pslverr  = 1'b0;

    case (r_r.st)
      S_FUSE_LOAD: begin
        r_nxt.rst_out_n = 1'b0;
        if (!r_r.busy && DIGITAL_CORE_OK && ANALOG_CORE_OK) begin
          r_nxt.busy     = 1'b1;
          r_nxt.fuse_req = 1'b1;
          r_nxt.func_req = CONFIG_SELECT_PIN;
        end else if (r_r.busy && FUSE_LOAD_DONE) begin
          r_nxt.busy     = 1'b0;
          r_nxt.trim_err = FUSE_TRIM_CRC_ERR;
          r_nxt.cfg_err  = FUSE_CFG_CRC_ERR;
          r_nxt.aon_cfg  = ~FUSE_TRIM_CRC_ERR & ~FUSE_CFG_CRC_ERR;
          r_nxt.st       = S_LOW_POWER_OFF_STATE;
        end
      end
      S_LOW_POWER_OFF_STATE: begin
        r_nxt.rst_out_n = 1'b0;
        r_nxt.armed     = 1'b0;
        // A hold count left from system-on would otherwise delay the first self-test.
        r_nxt.tmr       = '0;
        r_nxt.st_tries  = 2'h0;
        r_nxt.busy      = 1'b0;
        if (TEST_MODE_ENABLE_PIN || r_r.lpm) begin
          r_nxt.st = S_SELF_TEST;
        end else if (pu_event && env_ok && !r_r.trim_err && !r_r.cfg_err) begin
          r_nxt.armed = 1'b1;
          r_nxt.st    = S_SELF_TEST;
        end
        // Other events here are dropped; fuse errors keep the device off.
      end
      S_SELF_TEST: begin
        if (!r_r.busy) begin
          if (r_r.tmr != '0) begin
            r_nxt.tmr = r_r.tmr - 1'b1;
          end else begin
            r_nxt.busy     = 1'b1;
            r_nxt.st_start = 1'b1;
          end
        end else if (SELFTEST_DONE) begin
          r_nxt.busy = 1'b0;
          if (SELFTEST_PASS) begin
            r_nxt.stest_err = 1'b0;
            r_nxt.st        = S_QUICK_OFF;
          end else if (r_r.st_tries + 2'h1 < TRIES_T) begin
            // Retry after a settling gap so bandgap and clocks can settle.
            r_nxt.st_tries = r_r.st_tries + 2'h1;
            r_nxt.tmr      = GAP_T;
          end else if (!TEST_MODE_ENABLE_PIN) begin
            r_nxt.stest_err = 1'b1;
            r_nxt.st        = S_FS_TRANS;
            r_nxt.failsafe_counter    = r_r.failsafe_counter + 4'h1;
          end else begin
            r_nxt.stest_err = 1'b1;
            r_nxt.st        = S_QUICK_OFF;
          end
        end
      end
      S_QUICK_OFF: begin
        r_nxt.tmr = '0;
        if (r_r.armed && !r_r.lpm && !TEST_MODE_ENABLE_PIN && flags_ok) begin
          r_nxt.st       = S_POWER_UP;
          r_nxt.pu_start = 1'b1;
        end else if ((r_r.lpm || TEST_MODE_ENABLE_PIN) && pu_event && env_ok
                     && flags_ok) begin
          r_nxt.st       = S_POWER_UP;
          r_nxt.pu_start = 1'b1;
        end
        r_nxt.armed = 1'b0;
      end
      S_POWER_UP: begin
        if (POWERUP_FAIL) begin
          r_nxt.st       = S_PD_FAULT;
          r_nxt.pd_start = 1'b1;
        end else if (POWERUP_RESET_STEP) begin
          r_nxt.rst_out_n = 1'b1;
          r_nxt.st        = S_SYSTEM_ON;
          r_nxt.hold_arm  = 1'b0;
          r_nxt.tmr       = '0;
          r_nxt.sw_tmr    = '0;
          r_nxt.ov_tmr    = '0;
        end
      end
      S_SYSTEM_ON: begin
        if (fall) begin
          r_nxt.hold_arm = 1'b1;
          r_nxt.tmr      = '0;
        end else if (POWER_ON_PIN || !r_r.edge_mode) begin
          r_nxt.hold_arm = 1'b0;
        end else if (r_r.hold_arm && r_r.tmr < HOLD_T) begin
          r_nxt.tmr = r_r.tmr + 1'b1;
        end
        if (r_r.swoff && r_r.sw_tmr < SWOFF_T) begin
          r_nxt.sw_tmr = r_r.sw_tmr + 1'b1;
        end
        if (VIN_OVER_OV) begin
          if (r_r.ov_tmr < OVDB_T) begin
            r_nxt.ov_tmr = r_r.ov_tmr + 1'b1;
          end
        end else begin
          r_nxt.ov_tmr = '0;
        end
        // Faults win over a requested turn-off in the same cycle.
        if (fault_off) begin
          r_nxt.st        = S_PD_FAULT;
          r_nxt.rst_out_n = 1'b0;
          r_nxt.pd_start  = 1'b1;
        end else if (req_off) begin
          r_nxt.st        = S_PD_REQ;
          r_nxt.rst_out_n = 1'b0;
          r_nxt.pd_start  = 1'b1;
        end
      end
      S_PD_REQ: begin
        r_nxt.swoff    = 1'b0;
        r_nxt.hold_arm = 1'b0;
        if (POWERDOWN_DONE) begin
          r_nxt.st = S_LOW_POWER_OFF_STATE;
        end
      end
      S_PD_FAULT: begin
        r_nxt.rst_out_n = 1'b0;
        r_nxt.swoff     = 1'b0;
        if (POWERDOWN_DONE) begin
          r_nxt.st     = S_FS_TRANS;
          r_nxt.failsafe_counter = r_r.failsafe_counter + 4'h1;
        end
      end
      S_FS_TRANS: begin
        if (r_r.failsafe_counter < r_r.fs_lim || r_r.fs_bypass) begin
          r_nxt.st = S_LOW_POWER_OFF_STATE;
        end else begin
          r_nxt.st = S_FS_LOCK;
        end
      end
      S_FS_LOCK: begin
        r_nxt.rst_out_n = 1'b0;
      end
      default: begin
        r_nxt.st = S_FUSE_LOAD;
      end
    endcase

    // APB slave: the answer comes one cycle into the access phase, so every
    // bus output is a flip-flop; writes land on the edge that shows pready.
    if (apb_acc) begin
      r_nxt.pready = 1'b1;
      r_nxt.prdata = 32'h0000_0000;
      case (PADDR)
        CTRL_OFS: begin
          if (PWRITE) begin
            r_nxt.lpm       = PWDATA[CTRL_LPM_BIT];
            r_nxt.ovsd_en   = PWDATA[CTRL_OVSD_BIT];
            r_nxt.edge_mode = PWDATA[CTRL_EDGE_BIT];
            r_nxt.fs_bypass = PWDATA[CTRL_BYP_BIT];
            if (PWDATA[CTRL_SWOFF_BIT] && r_r.st == S_SYSTEM_ON && !r_r.swoff) begin
              r_nxt.swoff  = 1'b1;
              r_nxt.sw_tmr = '0;
            end
          end else begin
            r_nxt.prdata[CTRL_LPM_BIT]   = r_r.lpm;
            r_nxt.prdata[CTRL_SWOFF_BIT] = r_r.swoff;
            r_nxt.prdata[CTRL_OVSD_BIT]  = r_r.ovsd_en;
            r_nxt.prdata[CTRL_EDGE_BIT]  = r_r.edge_mode;
            r_nxt.prdata[CTRL_BYP_BIT]   = r_r.fs_bypass;
          end
        end
        LIMIT_OFS: begin
          if (PWRITE) begin
            r_nxt.fault_lim = PWDATA[3:0];
            r_nxt.fs_lim    = PWDATA[LIM_FS_LSB +: 4];
          end else begin
            r_nxt.prdata[3:0]            = r_r.fault_lim;
            r_nxt.prdata[LIM_FS_LSB +: 4] = r_r.fs_lim;
          end
        end
        STATUS_OFS: begin
          r_nxt.prdata[9:0]            = r_r.st;
          r_nxt.prdata[STAT_TRIM_BIT]  = r_r.trim_err;
          r_nxt.prdata[STAT_CFG_BIT]   = r_r.cfg_err;
          r_nxt.prdata[STAT_STEST_BIT] = r_r.stest_err;
          r_nxt.prdata[STAT_RST_BIT]   = r_r.rst_out_n;
        end
        COUNT_OFS: begin
          r_nxt.prdata[3:0]               = r_r.failsafe_counter;
          r_nxt.prdata[CNT_TRY_LSB +: 2]  = r_r.st_tries;
        end
        default: begin
          r_nxt.pslverr = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge SYS_CLK or negedge rst_sync2_r) begin
    if (!rst_sync2_r) begin
      r_r           <= '0;
      r_r.st        <= S_FUSE_LOAD;
      r_r.fault_lim <= FAULT_LIM_RST;
      r_r.fs_lim    <= FS_LIM_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    PREADY                = r_r.pready;
    PRDATA                = r_r.prdata;
    PSLVERR               = r_r.pslverr;
    PROCESSOR_RESET_OUT_N = r_r.rst_out_n;
    FUSE_LOAD_REQ         = r_r.fuse_req;
    FUNC_LOAD_REQ         = r_r.func_req;
    ALWAYS_ON_CFG         = r_r.aon_cfg;
    SELFTEST_START        = r_r.st_start;
    POWERUP_START         = r_r.pu_start;
    POWERDOWN_START       = r_r.pd_start;
    FAILSAFE_LOCKED       = (r_r.st == S_FS_LOCK);
    PMIC_STATE            = r_r.st;
  end

endmodule : pwr_state_machine

/* File: tb/pwr_partner.sv */
// Far-side model: fuse loader, self-test engine and rail sequencer.
// Assumes one-cycle start pulses from the state machine; answers after dly cycles.
`timescale 1ns/1ns
module pwr_partner (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       fuse_req,
  input  wire logic       st_start,
  input  wire logic       pu_start,
  input  wire logic       pd_start,
  input  wire logic       pu_bad,
  input  wire logic [3:0] dly,
  output logic            fuse_done,
  output logic            trim_err,
  output logic            cfg_err,
  output logic            st_done,
  output logic            st_pass,
  output logic            pu_step,
  output logic            pu_fail,
  output logic            pd_done
);
  logic [3:0] cnt;
  logic [1:0] op;
  // ==========================================================================
  // Answer logic
  // Fuses always load clean and self-test always passes; faults come from the bench.
  assign trim_err = 1'b0;
  assign cfg_err  = 1'b0;
  assign st_pass  = 1'b1;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      op <= 2'h0;
      {fuse_done, st_done, pu_step, pu_fail, pd_done} <= 5'h00;
    end else begin
      {fuse_done, st_done, pu_step, pu_fail, pd_done} <= 5'h00;
      if (fuse_req | st_start | pu_start | pd_start) begin
        cnt <= dly;
        op <= fuse_req ? 2'h0 : st_start ? 2'h1 : pu_start ? 2'h2 : 2'h3;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          case (op)
            2'h0: fuse_done <= 1'b1;
            2'h1: st_done <= 1'b1;
            2'h2: {pu_fail, pu_step} <= {pu_bad, !pu_bad};
            default: pd_done <= 1'b1;
          endcase
        end
      end
    end
  end
endmodule : pwr_partner

/* File: tb/pwr_state_machine_chk.sv */
// Port-level checks of the power state machine transitions.
// Assumes the one-hot state output and start pulses coincident with state entry.
`timescale 1ns/1ns
module pwr_sm_chk (
  input wire logic                    SYS_CLK,
  input wire logic                    RST_N,
  input wire logic                    DIGITAL_CORE_OK,
  input wire logic                    ANALOG_CORE_OK,
  input wire logic                    FUSE_LOAD_REQ,
  input wire logic                    FUSE_LOAD_DONE,
  input wire logic                    FUSE_TRIM_CRC_ERR,
  input wire logic                    FUSE_CFG_CRC_ERR,
  input wire logic                    POWERUP_START,
  input wire logic                    POWERUP_RESET_STEP,
  input wire logic                    POWERUP_FAIL,
  input wire logic                    POWERDOWN_DONE,
  input wire logic                    FAULT_TIMER_EXPIRED,
  input wire logic                    TJ_OVER_LIMIT,
  input wire logic                    PROCESSOR_RESET_OUT_N,
  input wire logic                    FAILSAFE_LOCKED,
  input wire pwr_seq_pkg::pwr_state_e PMIC_STATE
);
  import pwr_seq_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================================
  // Transitions
  fuse_req_a: assert property ($rose(DIGITAL_CORE_OK && ANALOG_CORE_OK) &&
    PMIC_STATE == S_FUSE_LOAD |-> ##[1:4] FUSE_LOAD_REQ) else $error("no fuse load request");
  fuse_done_a: assert property (PMIC_STATE == S_FUSE_LOAD && FUSE_LOAD_DONE &&
    !FUSE_TRIM_CRC_ERR && !FUSE_CFG_CRC_ERR |-> ##[1:3] PMIC_STATE == S_LOW_POWER_OFF_STATE)
    else $error("clean fuse load did not reach low-power off");
  pu_start_a: assert property ($rose(PMIC_STATE == S_POWER_UP) |-> POWERUP_START)
    else $error("power-up entered without start pulse");
  sys_on_a: assert property (PMIC_STATE == S_POWER_UP && POWERUP_RESET_STEP &&
    !POWERUP_FAIL |=> PMIC_STATE == S_SYSTEM_ON && PROCESSOR_RESET_OUT_N)
    else $error("reset release did not enter system-on");
  pu_fail_a: assert property (PMIC_STATE == S_POWER_UP && POWERUP_FAIL
    |=> PMIC_STATE == S_PD_FAULT) else $error("power-up failure not handled");
  fault_off_a: assert property (PMIC_STATE == S_SYSTEM_ON &&
    (FAULT_TIMER_EXPIRED || TJ_OVER_LIMIT) |=> PMIC_STATE == S_PD_FAULT)
    else $error("fault did not start fault power-down");
  req_done_a: assert property (PMIC_STATE == S_PD_REQ && POWERDOWN_DONE
    |=> PMIC_STATE == S_LOW_POWER_OFF_STATE) else $error("requested off did not reach low-power off");
  fault_done_a: assert property (PMIC_STATE == S_PD_FAULT && POWERDOWN_DONE
    |=> PMIC_STATE == S_FS_TRANS) else $error("fault off did not reach fail-safe");
  fs_exit_a: assert property (PMIC_STATE == S_FS_TRANS
    |=> PMIC_STATE inside {S_LOW_POWER_OFF_STATE, S_FS_LOCK}) else $error("fail-safe exit wrong");
  fs_lock_a: assert property (PMIC_STATE == S_FS_LOCK [*2] |-> FAILSAFE_LOCKED)
    else $error("locked state without lock flag");
endmodule : pwr_sm_chk

bind pwr_state_machine pwr_sm_chk chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .DIGITAL_CORE_OK(DIGITAL_CORE_OK), .ANALOG_CORE_OK(ANALOG_CORE_OK),
  .FUSE_LOAD_REQ(FUSE_LOAD_REQ), .FUSE_LOAD_DONE(FUSE_LOAD_DONE),
  .FUSE_TRIM_CRC_ERR(FUSE_TRIM_CRC_ERR), .FUSE_CFG_CRC_ERR(FUSE_CFG_CRC_ERR),
  .POWERUP_START(POWERUP_START), .POWERUP_RESET_STEP(POWERUP_RESET_STEP),
  .POWERUP_FAIL(POWERUP_FAIL), .POWERDOWN_DONE(POWERDOWN_DONE),
  .FAULT_TIMER_EXPIRED(FAULT_TIMER_EXPIRED), .TJ_OVER_LIMIT(TJ_OVER_LIMIT),
  .PROCESSOR_RESET_OUT_N(PROCESSOR_RESET_OUT_N), .FAILSAFE_LOCKED(FAILSAFE_LOCKED),
  .PMIC_STATE(PMIC_STATE));

/* File: tb/pwr_state_machine_test.sv */
// Self-checking bench of the power state machine over APB and its pins.
// Assumes the far-side model in pwr_partner and shortened timer parameters.
`timescale 1ns/1ns
module pwr_state_machine_test;
  import pwr_seq_pkg::*;
  localparam int SWOFF = 20;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, pin, tst, uv_ok, ov;
  logic        ov_dis, tj, cores, fuse_req, fuse_done, trim_err, cfg_err, st_start;
  logic        st_done, st_pass, pu_start, pu_step, pu_fail, pu_bad, pd_start, pd_done;
  logic        fault_tmr, rst_out_n, fs_locked, cfg_sel, func_req, aon_cfg, seen_func, seen_aon;
  logic [3:0]  dly, fault_counter;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  pwr_state_e  state;
  int          error_cnt, tests_run, cyc, n;

  pwr_state_machine #(.SWOFF_CYCLES(SWOFF), .ST_GAP_CYCLES(10), .HOLD_CYCLES(20)) dut (
    .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .POWER_ON_PIN(pin), .TEST_MODE_ENABLE_PIN(tst), .VIN_ABOVE_UV(uv_ok), .VIN_OVER_OV(ov),
    .OV_LOCKOUT_DISABLE(ov_dis), .TJ_OVER_LIMIT(tj), .DIGITAL_CORE_OK(cores),
    .ANALOG_CORE_OK(cores), .CONFIG_SELECT_PIN(cfg_sel), .FUSE_LOAD_DONE(fuse_done),
    .FUSE_TRIM_CRC_ERR(trim_err), .FUSE_CFG_CRC_ERR(cfg_err), .SELFTEST_DONE(st_done),
    .SELFTEST_PASS(st_pass), .POWERUP_RESET_STEP(pu_step), .POWERUP_FAIL(pu_fail),
    .POWERDOWN_DONE(pd_done), .FAULT_TIMER_EXPIRED(fault_tmr), .FAULT_COUNTER(fault_counter),
    .PROCESSOR_RESET_OUT_N(rst_out_n), .FUSE_LOAD_REQ(fuse_req), .FUNC_LOAD_REQ(func_req),
    .ALWAYS_ON_CFG(aon_cfg), .SELFTEST_START(st_start), .POWERUP_START(pu_start),
    .POWERDOWN_START(pd_start), .FAILSAFE_LOCKED(fs_locked), .PMIC_STATE(state));

  pwr_partner far (.clk(clk), .rst_n(rst_n), .fuse_req(fuse_req), .st_start(st_start),
    .pu_start(pu_start), .pd_start(pd_start), .pu_bad(pu_bad), .dly(dly),
    .fuse_done(fuse_done), .trim_err(trim_err), .cfg_err(cfg_err), .st_done(st_done),
    .st_pass(st_pass), .pu_step(pu_step), .pu_fail(pu_fail), .pd_done(pd_done));

  // ==========================================================================
  // Shared tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // The request is held until the edge at which the answer is sampled.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Each edge sees the state held in the cycle before it, so one-cycle states show.
  task automatic see(input pwr_state_e s);
    n = 0;
    while (state !== s && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(32'(state), 32'(s));
  endtask : see

  task automatic drive_pin(input logic v);
    @(posedge clk);
    pin <= v;
  endtask : drive_pin

  // ==========================================================================
  // Scenarios
  task automatic t_start;
    @(posedge clk);
    cores <= 1'b1;
    see(S_LOW_POWER_OFF_STATE);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(q, 32'h0000_0002);
    chk(32'({seen_func, seen_aon}), 32'h3);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(q & 32'h1, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(e), 32'h1);
    $display("start done");
  endtask : t_start

  task automatic t_on_off;
    drive_pin(1'b1);
    see(S_SELF_TEST);
    see(S_QUICK_OFF);
    see(S_POWER_UP);
    see(S_SYSTEM_ON);
    chk(32'(rst_out_n), 32'h1);
    drive_pin(1'b0);
    see(S_PD_REQ);
    see(S_LOW_POWER_OFF_STATE);
    $display("on off done");
  endtask : t_on_off

  task automatic t_swoff;
    dly <= 4'h9;
    drive_pin(1'b1);
    see(S_SYSTEM_ON);
    apb(1'b1, CTRL_OFS, 32'h2);
    see(S_PD_REQ);
    chk(32'(n >= SWOFF - 2 && n <= SWOFF + 4), 32'h1);
    drive_pin(1'b0);
    see(S_LOW_POWER_OFF_STATE);
    $display("software off done");
  endtask : t_swoff

  task automatic t_edge;
    apb(1'b1, CTRL_OFS, 32'h8);
    drive_pin(1'b1);
    repeat (5) @(posedge clk);
    chk(32'(state), 32'(S_LOW_POWER_OFF_STATE));
    drive_pin(1'b0);
    see(S_SYSTEM_ON);
    drive_pin(1'b1);
    drive_pin(1'b0);
    repeat (10) @(posedge clk);
    chk(32'(state), 32'(S_SYSTEM_ON));
    see(S_PD_REQ);
    see(S_LOW_POWER_OFF_STATE);
    apb(1'b1, CTRL_OFS, 32'h0);
    $display("edge mode done");
  endtask : t_edge

  task automatic t_quick;
    apb(1'b1, CTRL_OFS, 32'h1);
    see(S_QUICK_OFF);
    ov <= 1'b1;
    drive_pin(1'b1);
    repeat (5) @(posedge clk);
    chk(32'(state), 32'(S_QUICK_OFF));
    ov <= 1'b0;
    see(S_POWER_UP);
    see(S_SYSTEM_ON);
    apb(1'b1, CTRL_OFS, 32'h4);
    ov <= 1'b1;
    repeat (1250) @(posedge clk);
    chk(32'(state), 32'(S_SYSTEM_ON));
    see(S_PD_REQ);
    chk(32'(n), 32'h2);
    {pin, ov} <= 2'b00;
    see(S_LOW_POWER_OFF_STATE);
    $display("quick-off done");
  endtask : t_quick

  // Four fault cycles with the fail-safe limit raised to four: the fourth one locks.
  task automatic t_faults;
    apb(1'b0, LIMIT_OFS, 32'h0);
    chk(q & 32'hFF, 32'h33);
    apb(1'b1, LIMIT_OFS, 32'h43);
    for (int k = 1; k <= 4; k++) begin
      @(posedge clk);
      pu_bad <= (k == 1);
      pin <= 1'b1;
      if (k > 1) begin
        see(S_SYSTEM_ON);
        @(posedge clk);
        if (k == 2) fault_tmr <= 1'b1;
        else if (k == 3) fault_counter <= 4'h3;
        else tj <= 1'b1;
      end
      see(S_PD_FAULT);
      @(posedge clk);
      {pin, pu_bad, fault_tmr, tj, fault_counter} <= 8'h00;
      see(S_FS_TRANS);
      if (k < 4) see(S_LOW_POWER_OFF_STATE);
      else see(S_FS_LOCK);
      apb(1'b0, COUNT_OFS, 32'h0);
      chk(q & 32'hF, 32'(k));
    end
    chk(32'(fs_locked), 32'h1);
    $display("fail-safe done");
  endtask : t_faults

  // ==========================================================================
  // Clock, reset, timeout and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      end_sim();
    end
  end

  always @(posedge clk) begin
    if (func_req) seen_func <= 1'b1;
    if (aon_cfg) seen_aon <= 1'b1;
  end

  initial begin
    {rst_n, psel, penable, pwrite, pin, tst, ov, ov_dis, tj, cores} = '0;
    {pu_bad, fault_tmr, uv_ok, cfg_sel, seen_func, seen_aon} = 6'b001100;
    {paddr, pwdata, fault_counter, dly} = '0;
    dly = 4'h2;
    {error_cnt, tests_run, cyc} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_start();
    t_on_off();
    t_swoff();
    t_edge();
    t_quick();
    t_faults();
    end_sim();
  end
endmodule : pwr_state_machine_test
